// ==== src/tw_pkg.sv ====
// Package for the timer waveform output control block.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register slave.
package tw_pkg;
   // Register byte offsets (index times four)
   localparam logic [7:0] TW_IDX_CTRL_A = 8'hb0;
   localparam logic [7:0] TW_IDX_CTRL_B = 8'hb1;
   localparam logic [9:0] TW_ADDR_CTRL_A = {TW_IDX_CTRL_A, 2'b00};
   localparam logic [9:0] TW_ADDR_CTRL_B = {TW_IDX_CTRL_B, 2'b00};
   localparam logic [9:0] TW_ADDR_CMP_A = 10'h2c8;
   localparam logic [9:0] TW_ADDR_CMP_B = 10'h2cc;
   // Counter kept clear of control B so a mode write never loads the count
   localparam logic [9:0] TW_ADDR_COUNT = 10'h2d4;
   localparam logic [9:0] TW_ADDR_STATUS = 10'h2d0;
   localparam logic [7:0] TW_RESET_VAL = 8'h00;
   // Field positions
   localparam int TW_OMA_HI = 7;
   localparam int TW_OMA_LO = 6;
   localparam int TW_OMB_HI = 5;
   localparam int TW_OMB_LO = 4;
   localparam int TW_WGL_HI = 1;
   localparam int TW_WGL_LO = 0;
   localparam int TW_FMA_BIT = 7;
   localparam int TW_FMB_BIT = 6;
   localparam int TW_WG2_BIT = 3;
   localparam int TW_CS_HI = 2;
   localparam int TW_CS_LO = 0;
   localparam logic [7:0] TW_CTRL_A_MASK = 8'hf3;
   localparam logic [7:0] TW_CTRL_B_MASK = 8'h0f;
   // Counter limits
   localparam logic [7:0] TW_BOTTOM = 8'h00;
   localparam logic [7:0] TW_MAX = 8'hff;
   // Output mode codes
   localparam logic [1:0] TW_OM_OFF = 2'h0;
   localparam logic [1:0] TW_OM_TOG = 2'h1;
   localparam logic [1:0] TW_OM_CLR = 2'h2;
   localparam logic [1:0] TW_OM_SET = 2'h3;
   // Waveform modes
   localparam logic [2:0] TW_WG_NORMAL = 3'h0;
   localparam logic [2:0] TW_WG_PC_FF = 3'h1;
   localparam logic [2:0] TW_WG_CTC = 3'h2;
   localparam logic [2:0] TW_WG_FAST_FF = 3'h3;
   localparam logic [2:0] TW_WG_PC_CMP = 3'h5;
   localparam logic [2:0] TW_WG_FAST_CMP = 3'h7;
   // Prescaler divisors, indexed by clock_select
   localparam logic [9:0] TW_DIV_8 = 10'h007;
   localparam logic [9:0] TW_DIV_32 = 10'h01f;
   localparam logic [9:0] TW_DIV_64 = 10'h03f;
   localparam logic [9:0] TW_DIV_128 = 10'h07f;
   localparam logic [9:0] TW_DIV_256 = 10'h0ff;
   localparam logic [9:0] TW_DIV_1024 = 10'h3ff;
   localparam logic [2:0] TW_CS_STOP = 3'h0;
   localparam logic [2:0] TW_CS_DIRECT = 3'h1;

   // Bus response state
   typedef enum logic [1:0] {
      TW_BUS_IDLE = 2'b01,
      TW_BUS_DONE = 2'b10
   } tw_bus_t;

   // Pin group for one waveform channel
   typedef struct packed {
      logic level;
      logic take_pin;
      logic drive_en;
   } tw_pin_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] cmp_a_buf;
      logic [7:0] cmp_b_buf;
      logic [7:0] count;
      logic down;
      logic [9:0] presc;
      logic wave_a;
      logic wave_b;
      logic ovf;
      logic match_a;
      logic match_b;
      tw_bus_t bus;
      logic [31:0] rdata;
      logic waitreq;
      tw_pin_t pin_a;
      tw_pin_t pin_b;
   } tw_state_t;
endpackage

// ==== src/tw_wave_ctrl.sv ====
// Timer waveform output control: counter, modes, compare outputs, force strobes.
// Assumes pin direction bits arrive as inputs and a master that holds requests until waitrequest is low.
// Contract
// - Nonzero channel A output mode gives its pin to wave_out_a.
// - Nonzero channel B output mode gives its pin to wave_out_b.
// - Pin driver enabled only when the pin direction bit is set.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 01 toggles only with mode bit2; 10/11 clear/set, inverse at BOTTOM.
// - Fast PWM B: 01 reserved; 10 clear/BOTTOM set, 11 set/BOTTOM clear.
// - Fast PWM compare equal TOP with high bit: act at BOTTOM instead.
// - Phase correct A: 01 as fast PWM; 10/11 act by count direction.
// - Phase correct B: 01 reserved; 10/11 act by count direction.
// - Phase correct compare equal TOP with high bit: act at TOP instead.
// - Control A bits 3:2 always read zero.
// - Three-bit wave mode picks sequence, TOP and waveform; 4 and 6 reserved.
// - Modes 0 and 2: TOP 0xFF or compare A, immediate update, overflow at MAX.
// - Modes 1 and 5: phase correct, load at TOP, overflow at BOTTOM.
// - Modes 3 and 7: fast PWM, load at BOTTOM, overflow at MAX or TOP.
// - Force A acts only in non-PWM modes.
// - Force A forces an immediate match using current output mode.
// - Forced match raises no flag and never clears the counter.
// - Force A reads back as zero.
// - Clock select: stop, direct, then divide by 8,32,64,128,256,1024.
// - Force B mirrors force A on channel B.
`timescale 1ns/1ps
module tw_wave_ctrl
   import tw_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   input wire logic dir_a_i,
   input wire logic dir_b_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   output logic wave_out_a_o,
   output logic wave_out_a_take_o,
   output logic wave_out_a_en_o,
   output logic wave_out_b_o,
   output logic wave_out_b_take_o,
   output logic wave_out_b_en_o,
   output logic overflow_flag_o,
   output logic match_a_o,
   output logic match_b_o
);
   // Elaboration check: decode needs the full register address range
   if (ADDR_W != 10) begin : g_bad_addr
      $error("tw_wave_ctrl supports ADDR_W of 10 only");
   end

   tw_state_t st;
   tw_state_t next_st;

   logic [2:0] wgm;
   logic [2:0] cs;
   logic [1:0] om_a;
   logic [1:0] om_b;
   logic pwm;
   logic pc_mode;
   logic fast_mode;
   logic [7:0] top;
   logic tick;
   logic [9:0] div_mask;
   logic wr_a;
   logic wr_b;
   logic at_top;
   logic at_bottom;
   logic hit_a;
   logic hit_b;

   // Mode decode from both control registers
   always_comb begin
      wgm = {st.ctrl_b[TW_WG2_BIT], st.ctrl_a[TW_WGL_HI:TW_WGL_LO]};
      cs = st.ctrl_b[TW_CS_HI:TW_CS_LO];
      om_a = st.ctrl_a[TW_OMA_HI:TW_OMA_LO];
      om_b = st.ctrl_a[TW_OMB_HI:TW_OMB_LO];
      pc_mode = (wgm == TW_WG_PC_FF) || (wgm == TW_WG_PC_CMP);
      fast_mode = (wgm == TW_WG_FAST_FF) || (wgm == TW_WG_FAST_CMP);
      pwm = pc_mode || fast_mode;
      // TOP source per mode
      top = (wgm == TW_WG_CTC || wgm == TW_WG_PC_CMP || wgm == TW_WG_FAST_CMP) ? st.cmp_a : TW_MAX;
   end

   // Prescaler divisor select
   always_comb begin
      unique case (cs)
         3'h2: div_mask = TW_DIV_8;
         3'h3: div_mask = TW_DIV_32;
         3'h4: div_mask = TW_DIV_64;
         3'h5: div_mask = TW_DIV_128;
         3'h6: div_mask = TW_DIV_256;
         3'h7: div_mask = TW_DIV_1024;
         default: div_mask = 10'h000;
      endcase
      tick = (cs == TW_CS_DIRECT) || ((cs != TW_CS_STOP) && ((st.presc & div_mask) == div_mask));
   end

   // Bus write strobes; low byte lane carries register data.
   // A write lands at the answer edge, where the master sees waitrequest low,
   // so the effect and the completed transfer fall on one edge.
   // The master still holds address and data there, as the bus demands.
   always_comb begin
      wr_a = write_i && (st.bus == TW_BUS_DONE) && byteenable_i[0] && (address_i == TW_ADDR_CTRL_A);
      wr_b = write_i && (st.bus == TW_BUS_DONE) && byteenable_i[0] && (address_i == TW_ADDR_CTRL_B);
   end

   // Reserved top-equal codes never fire the sequence-position flags wrongly
   always_comb begin
      at_top = (st.count == top);
      at_bottom = (st.count == TW_BOTTOM);
      // Real matches only on timer ticks
      hit_a = tick && (st.count == st.cmp_a);
      hit_b = tick && (st.count == st.cmp_b);
   end

   // Next state: counter, outputs, registers, bus
   always_comb begin
      next_st = st;
      next_st.match_a = 1'b0;
      next_st.match_b = 1'b0;
      next_st.ovf = 1'b0;
      next_st.presc = (cs == TW_CS_STOP) ? 10'h000 : st.presc + 10'h001;

      // Counter sequence
      // Phase correct turns at TOP and at BOTTOM; the others wrap after TOP.
      // Limitation: a TOP lowered below the count runs on through 0xff first.
      if (tick) begin
         if (pc_mode) begin
            if (!st.down && at_top) begin
               next_st.down = 1'b1;
               next_st.count = st.count - 8'h01;
               next_st.cmp_a = st.cmp_a_buf; // Load at TOP
               next_st.cmp_b = st.cmp_b_buf;
            end else if (st.down && at_bottom) begin
               next_st.down = 1'b0;
               next_st.count = st.count + 8'h01;
            end else begin
               next_st.count = st.down ? st.count - 8'h01 : st.count + 8'h01;
            end
            if (st.down && st.count == 8'h01) begin
               next_st.ovf = 1'b1; // Overflow at BOTTOM
            end
         end else begin
            next_st.down = 1'b0;
            next_st.count = at_top ? TW_BOTTOM : st.count + 8'h01;
            if (fast_mode && at_top) begin
               next_st.cmp_a = st.cmp_a_buf; // Load at BOTTOM
               next_st.cmp_b = st.cmp_b_buf;
            end
            // Overflow at MAX, or at TOP in mode 7
            if ((wgm == TW_WG_FAST_CMP) ? at_top : (st.count == TW_MAX)) begin
               next_st.ovf = 1'b1;
            end
         end
         next_st.match_a = hit_a;
         next_st.match_b = hit_b;
      end

      // Channel A waveform
      if (!pwm) begin
         if (hit_a) begin
            unique case (om_a)
               TW_OM_TOG: next_st.wave_a = ~st.wave_a;
               TW_OM_CLR: next_st.wave_a = 1'b0;
               TW_OM_SET: next_st.wave_a = 1'b1;
               default: next_st.wave_a = st.wave_a;
            endcase
         end
      end else if (tick) begin
         if (om_a == TW_OM_TOG) begin
            if (st.ctrl_b[TW_WG2_BIT] && hit_a) begin
               next_st.wave_a = ~st.wave_a;
            end
         end else if (om_a[1]) begin
            if (fast_mode) begin
               if (at_top) begin
                  next_st.wave_a = ~om_a[0]; // BOTTOM action
               end else if (hit_a) begin
                  next_st.wave_a = om_a[0];
               end
            end else if (st.cmp_a == top) begin
               if (at_top) begin
                  next_st.wave_a = om_a[0]; // Act at TOP
               end
            end else if (hit_a) begin
               next_st.wave_a = om_a[0] ^ st.down;
            end
         end
      end

      // Channel B waveform; code 01 reserved in PWM
      if (!pwm) begin
         if (hit_b) begin
            unique case (om_b)
               TW_OM_TOG: next_st.wave_b = ~st.wave_b;
               TW_OM_CLR: next_st.wave_b = 1'b0;
               TW_OM_SET: next_st.wave_b = 1'b1;
               default: next_st.wave_b = st.wave_b;
            endcase
         end
      end else if (tick && om_b[1]) begin
         if (fast_mode) begin
            if (at_top) begin
               next_st.wave_b = ~om_b[0];
            end else if (hit_b && st.cmp_b != top) begin
               next_st.wave_b = om_b[0];
            end
         end else if (st.cmp_b == top) begin
            if (at_top) begin
               next_st.wave_b = om_b[0];
            end
         end else if (hit_b) begin
            next_st.wave_b = om_b[0] ^ st.down;
         end
      end

      // Force strobes: no flag, no counter clear
      // They act on the output only, never on match or overflow pulses.
      // Reserved modes decode as non-PWM, so the strobes act there too.
      if (wr_b && !pwm && writedata_i[TW_FMA_BIT]) begin
         unique case (om_a)
            TW_OM_TOG: next_st.wave_a = ~st.wave_a;
            TW_OM_CLR: next_st.wave_a = 1'b0;
            TW_OM_SET: next_st.wave_a = 1'b1;
            default: next_st.wave_a = st.wave_a;
         endcase
      end
      if (wr_b && !pwm && writedata_i[TW_FMB_BIT]) begin
         unique case (om_b)
            TW_OM_TOG: next_st.wave_b = ~st.wave_b;
            TW_OM_CLR: next_st.wave_b = 1'b0;
            TW_OM_SET: next_st.wave_b = 1'b1;
            default: next_st.wave_b = st.wave_b;
         endcase
      end

      // Register writes; force bits are never stored
      if (wr_a) begin
         next_st.ctrl_a = writedata_i[7:0] & TW_CTRL_A_MASK;
      end
      if (wr_b) begin
         next_st.ctrl_b = writedata_i[7:0] & TW_CTRL_B_MASK;
      end
      // In PWM modes only the buffer takes the value, so a duty change never
      // cuts a period short; reads return the buffer.
      if (write_i && st.bus == TW_BUS_DONE && byteenable_i[0]) begin
         if (address_i == TW_ADDR_CMP_A) begin
            next_st.cmp_a_buf = writedata_i[7:0];
            if (!pwm) begin
               next_st.cmp_a = writedata_i[7:0]; // Immediate update
            end
         end
         if (address_i == TW_ADDR_CMP_B) begin
            next_st.cmp_b_buf = writedata_i[7:0];
            if (!pwm) begin
               next_st.cmp_b = writedata_i[7:0];
            end
         end
         if (address_i == TW_ADDR_COUNT) begin
            next_st.count = writedata_i[7:0];
         end
      end

      // One wait cycle, then answer; unmapped reads return zero.
      // Each access costs two cycles; the trade buys registered read data.
      unique case (st.bus)
         TW_BUS_IDLE: begin
            next_st.waitreq = 1'b1;
            if (read_i || write_i) begin
               next_st.bus = TW_BUS_DONE;
               next_st.waitreq = 1'b0;
               next_st.rdata = 32'h0000_0000;
               if (read_i) begin
                  unique case (address_i)
                     TW_ADDR_CTRL_A: next_st.rdata[7:0] = st.ctrl_a;
                     TW_ADDR_CTRL_B: next_st.rdata[7:0] = st.ctrl_b;
                     TW_ADDR_CMP_A: next_st.rdata[7:0] = st.cmp_a_buf;
                     TW_ADDR_CMP_B: next_st.rdata[7:0] = st.cmp_b_buf;
                     TW_ADDR_COUNT: next_st.rdata[7:0] = st.count;
                     TW_ADDR_STATUS: next_st.rdata[3:0] = {st.down, st.wave_b, st.wave_a, wgm == 3'h4 || wgm == 3'h6};
                     default: next_st.rdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         TW_BUS_DONE: begin
            next_st.bus = TW_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
         default: begin
            next_st.bus = TW_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase

      // Pin ownership and drive
      next_st.pin_a.take_pin = |next_st.ctrl_a[TW_OMA_HI:TW_OMA_LO];
      next_st.pin_b.take_pin = |next_st.ctrl_a[TW_OMB_HI:TW_OMB_LO];
      next_st.pin_a.drive_en = next_st.pin_a.take_pin && dir_a_i;
      next_st.pin_b.drive_en = next_st.pin_b.take_pin && dir_b_i;
      next_st.pin_a.level = next_st.wave_a;
      next_st.pin_b.level = next_st.wave_b;
   end

   // Single state register
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.bus <= TW_BUS_IDLE;
         st.waitreq <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign readdata_o = st.rdata;
   assign waitrequest_o = st.waitreq;
   assign wave_out_a_o = st.pin_a.level;
   assign wave_out_a_take_o = st.pin_a.take_pin;
   assign wave_out_a_en_o = st.pin_a.drive_en;
   assign wave_out_b_o = st.pin_b.level;
   assign wave_out_b_take_o = st.pin_b.take_pin;
   assign wave_out_b_en_o = st.pin_b.drive_en;
   assign overflow_flag_o = st.ovf;
   assign match_a_o = st.match_a;
   assign match_b_o = st.match_b;
endmodule // tw_wave_ctrl

// ==== sim/tw_wave_ctrl_monitor.sv ====
// Checker for the timer waveform block: bus answer and pin relations.
// Sees only the top module ports; bound to every instance below.
`timescale 1ns/1ps
module tw_wave_ctrl_monitor
   import tw_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [9:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic dir_a_i,
   input wire logic dir_b_i,
   input wire logic [31:0] readdata_o,
   input wire logic waitrequest_o,
   input wire logic wave_out_a_take_o,
   input wire logic wave_out_a_en_o,
   input wire logic wave_out_b_take_o,
   input wire logic wave_out_b_en_o,
   input wire logic overflow_flag_o,
   input wire logic match_a_o,
   input wire logic match_b_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Request start, read answer and a forced match with the clock stopped
   sequence s_take;
      $rose(read_i || write_i);
   endsequence
   sequence s_answer(logic [9:0] adr);
      read_i && !waitrequest_o && address_i == adr;
   endsequence
   sequence s_force_idle;
      $rose(write_i) && address_i == TW_ADDR_CTRL_B && writedata_i[7:6] != 2'b00 && writedata_i[2:0] == 3'h0;
   endsequence
   a_bus_answer: assert property (s_take |=> !waitrequest_o) else $error("no answer one cycle after request");
   a_answer_once: assert property (!waitrequest_o |=> waitrequest_o) else $error("answer longer than one cycle");
   a_en_a_cause: assert property (wave_out_a_en_o |-> wave_out_a_take_o && $past(dir_a_i))
      else $error("channel A driver on without take and direction");
   a_en_b_cause: assert property (wave_out_b_en_o |-> wave_out_b_take_o && $past(dir_b_i))
      else $error("channel B driver on without take and direction");
   a_en_a_follow: assert property ((wave_out_a_take_o && dir_a_i) ##1 wave_out_a_take_o |-> wave_out_a_en_o)
      else $error("channel A driver off while taken and output");
   a_rsvd_zero: assert property (s_answer(TW_ADDR_CTRL_A) |-> readdata_o[3:2] == 2'b00)
      else $error("control A reserved bits not zero");
   a_force_read: assert property (s_answer(TW_ADDR_CTRL_B) |-> readdata_o[7:4] == 4'h0)
      else $error("force strobes or reserved bits read nonzero");
   a_force_quiet: assert property (s_force_idle |=> ##1 !match_a_o && !match_b_o && !overflow_flag_o)
      else $error("forced match raised a flag");
   a_ovf_pulse: assert property (overflow_flag_o |=> !overflow_flag_o)
      else $error("overflow pulse longer than one cycle");
endmodule // tw_wave_ctrl_monitor

bind tw_wave_ctrl tw_wave_ctrl_monitor u_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .address_i(address_i),
   .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .dir_a_i(dir_a_i), .dir_b_i(dir_b_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .wave_out_a_take_o(wave_out_a_take_o),
   .wave_out_a_en_o(wave_out_a_en_o), .wave_out_b_take_o(wave_out_b_take_o), .wave_out_b_en_o(wave_out_b_en_o),
   .overflow_flag_o(overflow_flag_o), .match_a_o(match_a_o), .match_b_o(match_b_o));

// ==== sim/tw_wave_ctrl_tb_top.sv ====
// Testbench for the timer waveform block: registers, pins, force, periods, duty.
// Drives the Avalon-MM slave and the pin direction inputs itself.
`timescale 1ns/1ps
module tw_wave_ctrl_tb_top
   import tw_pkg::*;
;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [9:0] address_i = 10'h000;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic dir_a_i = 1'b1;
   logic dir_b_i = 1'b1;
   logic [31:0] readdata_o;
   logic waitrequest_o, wave_out_a_o, wave_out_a_take_o, wave_out_a_en_o;
   logic wave_out_b_o, wave_out_b_take_o, wave_out_b_en_o, overflow_flag_o, match_a_o, match_b_o;
   int fail_count = 0;
   int checked = 0;
   // Mode table for period tests: mode, compare A, watched pulse, period
   logic [2:0] pm [8] = '{3'h0, 3'h0, 3'h2, 3'h3, 3'h7, 3'h1, 3'h5, 3'h0};
   logic [7:0] pc [8] = '{8'h10, 8'h10, 8'h0f, 8'h10, 8'h1f, 8'h10, 8'h20, 8'h10};
   int ps [8] = '{0, 1, 1, 0, 0, 0, 0, 2};
   int pe [8] = '{256, 256, 16, 256, 32, 510, 64, 256};
   logic [1:0] fc [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
   logic fw [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   always #5 mclk_i = ~mclk_i;

   tw_wave_ctrl u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf), .dir_a_i(dir_a_i), .dir_b_i(dir_b_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .wave_out_a_o(wave_out_a_o),
      .wave_out_a_take_o(wave_out_a_take_o), .wave_out_a_en_o(wave_out_a_en_o), .wave_out_b_o(wave_out_b_o),
      .wave_out_b_take_o(wave_out_b_take_o), .wave_out_b_en_o(wave_out_b_en_o),
      .overflow_flag_o(overflow_flag_o), .match_a_o(match_a_o), .match_b_o(match_b_o));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_n(input int got, input int exp);
      checked++;
      if (got != exp) begin
         fail_count++;
         $display("ERROR t=%0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   // One Avalon cycle; request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge mclk_i);
      address_i <= a;
      writedata_i <= {24'h0, d};
      write_i <= wr;
      read_i <= !wr;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      q = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         $display("ERROR t=%0t bus answer timeout", $time);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, exp});
   endtask
   task automatic mode(input logic [2:0] m, input logic [3:0] om, input logic [2:0] cs);
      wr(TW_ADDR_CTRL_A, {om, 2'b00, m[1:0]});
      wr(TW_ADDR_CTRL_B, {4'h0, m[2], cs});
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return overflow_flag_o;
         1: return match_a_o;
         default: return match_b_o;
      endcase
   endfunction
   task automatic wait_hit(input int sel);
      int n;
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (pick(sel) !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         fail_count++;
         $display("ERROR t=%0t pulse wait timeout", $time);
      end
   endtask
   // Second gap measured, so buffered compare values have loaded
   task automatic gap(input int sel, output int n);
      wait_hit(sel);
      wait_hit(sel);
      n = 0;
      do begin
         @(negedge mclk_i);
         n++;
      end while (pick(sel) !== 1'b1 && n < 20000);
   endtask
   task automatic duty(input int p, output int ha, output int hb);
      wait_hit(0);
      wait_hit(0);
      ha = 0;
      hb = 0;
      repeat (p) begin
         @(negedge mclk_i);
         ha += (wave_out_a_o === 1'b1);
         hb += (wave_out_b_o === 1'b1);
      end
   endtask
   task automatic close_out;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog well beyond the roughly 45k cycles the tests need
   initial begin
      #1_000_000;
      fail_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      int ha, hb, ha2, hb2, n;
      repeat (3) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      rd_chk(TW_ADDR_CTRL_A, 8'h00);
      rd_chk(TW_ADDR_CTRL_B, 8'h00);
      rd_chk(10'h3fc, 8'h00);
      wr(TW_ADDR_CTRL_A, 8'hfc);
      rd_chk(TW_ADDR_CTRL_A, 8'hf0);
      wr(TW_ADDR_CTRL_B, 8'hf7);
      rd_chk(TW_ADDR_CTRL_B, 8'h07);
      wr(TW_ADDR_CTRL_B, 8'h00);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(TW_ADDR_CTRL_A, {c[1:0], c[1:0], 4'h0});
         @(negedge mclk_i);
         chk({wave_out_a_take_o, wave_out_a_en_o, wave_out_b_take_o, wave_out_b_en_o}, {4{c != 0}});
      end
      @(posedge mclk_i);
      dir_a_i <= 1'b0;
      dir_b_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      chk({wave_out_a_take_o, wave_out_a_en_o, wave_out_b_take_o, wave_out_b_en_o}, 4'b1010);
      @(posedge mclk_i);
      dir_a_i <= 1'b1;
      dir_b_i <= 1'b1;
      $display("test pins done");
      // Forced matches with the clock stopped, so only the strobe moves the outputs
      for (int i = 0; i < 4; i++) begin
         wr(TW_ADDR_CTRL_A, {fc[i], fc[i], 4'h0});
         wr(TW_ADDR_CTRL_B, 8'hc0);
         @(negedge mclk_i);
         chk({wave_out_a_o, wave_out_b_o}, {2{fw[i]}});
      end
      wr(TW_ADDR_CTRL_A, 8'hf3);
      wr(TW_ADDR_CTRL_B, 8'hc0);
      @(negedge mclk_i);
      chk({wave_out_a_o, wave_out_b_o}, 2'b00);
      $display("test force done");
      for (int i = 0; i < 8; i++) begin
         wr(TW_ADDR_CMP_A, pc[i]);
         mode(pm[i], 4'h0, 3'h1);
         gap(ps[i], n);
         chk_n(n, pe[i]);
      end
      for (int cs = 2; cs < 4; cs++) begin
         mode(3'h0, 4'h0, cs[2:0]);
         gap(0, n);
         chk_n(n, (cs == 2) ? 2048 : 8192);
      end
      mode(3'h0, 4'h0, 3'h0);
      n = 0;
      repeat (600) begin
         @(negedge mclk_i);
         n += (overflow_flag_o === 1'b1);
      end
      chk_n(n, 0);
      $display("test periods done");
      wr(TW_ADDR_CMP_A, 8'h40);
      wr(TW_ADDR_CMP_B, 8'h60);
      mode(3'h3, 4'ha, 3'h1);
      duty(256, ha, hb);
      wr(TW_ADDR_CMP_A, 8'h60);
      duty(256, ha2, hb2);
      chk_n(ha2 - ha, 32);
      chk_n(ha2, hb2);
      mode(3'h3, 4'hf, 3'h1);
      duty(256, ha, hb);
      chk_n(ha + ha2, 256);
      chk_n(hb + hb2, 256);
      wr(TW_ADDR_CMP_A, 8'hff);
      mode(3'h3, 4'h8, 3'h1);
      duty(256, ha, hb);
      chk_n(ha, 256);
      wr(TW_ADDR_CMP_A, 8'h40);
      mode(3'h1, 4'ha, 3'h1);
      duty(510, ha, hb);
      chk_n(hb - ha, 64);
      mode(3'h1, 4'hf, 3'h1);
      duty(510, ha2, hb2);
      chk_n(ha + ha2, 510);
      chk_n(hb + hb2, 510);
      $display("test duty done");
      close_out();
   end
endmodule // tw_wave_ctrl_tb_top
